// [hw/ttc_pkg.sv]
// Package: register map, field layout, reset values and timing for the thermal throttle control
package ttc_pkg;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_ONDEMAND = 8'h04;
	localparam logic [7:0] ADDR_OP_REQ   = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0c;
	localparam logic [7:0] ADDR_INT_STAT = 8'h10;
	localparam logic [7:0] ADDR_INT_CLR  = 8'h14;
	localparam logic [7:0] ADDR_INT_EN   = 8'h18;

	// ==========================================================
	// Field positions
	localparam int CTRL_AUTO_BIT    = 0;
	localparam int CTRL_VARIANT_BIT = 1;
	localparam int OD_EN_BIT        = 4;
	localparam int OD_DUTY_LSB      = 1;
	localparam int INT_START_BIT    = 0;
	localparam int INT_END_BIT      = 1;
	localparam int INT_TRIP_BIT     = 2;
	localparam int INT_W            = 3;
	localparam int OP_W             = 8;

	// ==========================================================
	// Reset values, low operating point and half duty
	localparam logic [OP_W-1:0]  OP_REQ_RST = 8'hff;
	localparam logic [OP_W-1:0]  OP_LOW     = 8'h00;
	localparam logic [2:0]       DUTY_HALF  = 3'h4;
	localparam logic [INT_W-1:0] INT_EN_RST = 3'h0;

	// ==========================================================
	// Timing
	localparam int CLK_NS    = 40;
	localparam int SLOT_NS   = 400;
	localparam int HYST_NS   = 1000;
	localparam int SLOT_CYC  = (SLOT_NS / CLK_NS) < 1 ? 1 : (SLOT_NS / CLK_NS);
	localparam int HYST_CYC  = (HYST_NS + CLK_NS - 1) / CLK_NS;
	localparam int SLOTS     = 8;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		TTC_IDLE   = 2'b00,
		TTC_ACTIVE = 2'b01,
		TTC_COOL   = 2'b11
	} ttc_state_t;

	typedef struct packed {
		logic variant;
		logic auto_en;
	} ttc_ctrl_t;

	typedef struct packed {
		logic       en;
		logic [2:0] duty;
	} ttc_od_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} ttc_bus_t;
endpackage : ttc_pkg

// [hw/ttc_top.sv]
// Thermal throttle control: trip detection, clock modulation, operating-point fallback, interrupts
//
// What this block does
// - Throttle circuit turns on when die temperature indication reaches the trip point.
// - Trip temperature is fixed in hardware, neither writable nor readable.
// - Bus snooping continues unchanged while throttling.
// - Interrupts are latched while throttling, serviced only when core clocks run.
// - Throttling gates core clocks or requests a lower operating point.
// - Automatic and on-demand activation exist; automatic wins when both apply.
// - Software selects clock modulation or operating-point automatic variant.
// - Automatic throttling asserts at the trip point and stays on for the hysteresis time after the die cools.
// - Operating-point variant drops to a lower operating point when hot.
// - On cooling, return to the operating point software last requested.
// - Automatic clock modulation runs at 50% duty with hysteresis at the trip.
// - On-demand bit 4 throttles at once; bits 3:1 set duty in eighths.
// - Hot output follows temperature; not newly set in clock-stopped states.
// - Catastrophic trip output asserts and shuts down, with no bus cycles.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module ttc_top (
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        rst_n,
	// Register port
	input  wire logic [7:0]                  addr,
	input  wire logic [31:0]                 wdata,
	input  wire logic                        wr,
	input  wire logic                        rd,
	output logic      [31:0]                 rdata,
	// Temperature indications (asynchronous)
	input  wire logic                        over_temp_async,
	input  wire logic                        crit_temp_async,
	// Core side
	input  wire logic                        low_power_state,
	input  wire logic                        snoop_req,
	output logic                             snoop_ack,
	input  wire logic                        irq_req,
	input  wire logic                        irq_taken,
	output logic                             irq_service,
	output logic                             core_clk_en,
	output logic      [ttc_pkg::OP_W-1:0]    op_point,
	// Thermal outputs
	output logic                             die_hot_output,
	output logic                             catastrophic_trip_output,
	output logic                             throttle_circuit,
	output logic                             irq
);
	// ==========================================================
	// Bus capture
	ttc_pkg::ttc_bus_t bus;
	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// ==========================================================
	// Synchronisers
	logic [2:0] hot_sync_reg;
	logic [2:0] crit_sync_reg;
	logic       hot_reg;
	logic       crit_reg;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hot_sync_reg  <= 3'h0;
			crit_sync_reg <= 3'h0;
		end else begin
			hot_sync_reg  <= {hot_sync_reg[1:0], over_temp_async};
			crit_sync_reg <= {crit_sync_reg[1:0], crit_temp_async};
		end
	end

	// Change accepted once second and third stage agree
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hot_reg  <= 1'b0;
			crit_reg <= 1'b0;
		end else begin
			if (hot_sync_reg[1] == hot_sync_reg[2]) begin
				hot_reg <= hot_sync_reg[2];
			end
			if (crit_sync_reg[1] == crit_sync_reg[2]) begin
				crit_reg <= crit_sync_reg[2];
			end
		end
	end

	// ==========================================================
	// Configuration registers
	ttc_pkg::ttc_ctrl_t             ctrl_reg;
	ttc_pkg::ttc_od_t               od_reg;
	logic [ttc_pkg::OP_W-1:0]       op_req_reg;
	logic [ttc_pkg::INT_W-1:0]      int_en_reg;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_reg   <= '0;
			od_reg     <= '0;
			op_req_reg <= ttc_pkg::OP_REQ_RST;
			int_en_reg <= ttc_pkg::INT_EN_RST;
		end else if (bus.wr) begin
			case (bus.addr)
				ttc_pkg::ADDR_CTRL: begin
					ctrl_reg.auto_en <= bus.wdata[ttc_pkg::CTRL_AUTO_BIT];
					ctrl_reg.variant <= bus.wdata[ttc_pkg::CTRL_VARIANT_BIT];
				end
				ttc_pkg::ADDR_ONDEMAND: begin
					od_reg.en   <= bus.wdata[ttc_pkg::OD_EN_BIT];
					od_reg.duty <= bus.wdata[ttc_pkg::OD_DUTY_LSB +: 3];
				end
				ttc_pkg::ADDR_OP_REQ: begin
					op_req_reg <= bus.wdata[ttc_pkg::OP_W-1:0];
				end
				ttc_pkg::ADDR_INT_EN: begin
					int_en_reg <= bus.wdata[ttc_pkg::INT_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Automatic mode state machine with hysteresis
	ttc_pkg::ttc_state_t state_reg;
	ttc_pkg::ttc_state_t state_next;
	logic [7:0]          hyst_cnt_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ttc_pkg::TTC_IDLE: begin
				if (ctrl_reg.auto_en && hot_reg) begin
					state_next = ttc_pkg::TTC_ACTIVE;
				end
			end
			ttc_pkg::TTC_ACTIVE: begin
				if (!ctrl_reg.auto_en) begin
					state_next = ttc_pkg::TTC_IDLE;
				end else if (!hot_reg) begin
					state_next = ttc_pkg::TTC_COOL;
				end
			end
			ttc_pkg::TTC_COOL: begin
				if (!ctrl_reg.auto_en) begin
					state_next = ttc_pkg::TTC_IDLE;
				end else if (hot_reg) begin
					state_next = ttc_pkg::TTC_ACTIVE;
				end else if (hyst_cnt_reg == 8'(ttc_pkg::HYST_CYC - 1)) begin
					state_next = ttc_pkg::TTC_IDLE;
				end
			end
			default: begin
				state_next = ttc_pkg::TTC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= ttc_pkg::TTC_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hyst_cnt_reg <= 8'h00;
		end else if (state_reg == ttc_pkg::TTC_COOL && state_next == ttc_pkg::TTC_COOL) begin
			hyst_cnt_reg <= hyst_cnt_reg + 8'h01;
		end else begin
			hyst_cnt_reg <= 8'h00;
		end
	end

	// ==========================================================
	// Activation sources and precedence
	logic auto_act;
	logic auto_clk;
	logic auto_op;
	logic mod_act;
	logic [2:0] duty;

	assign auto_act = state_reg != ttc_pkg::TTC_IDLE;
	assign auto_clk = auto_act && !ctrl_reg.variant;
	assign auto_op  = auto_act && ctrl_reg.variant;
	// Automatic overrides on-demand settings while it is active
	assign mod_act  = auto_clk || (!auto_act && od_reg.en);
	assign duty     = (auto_clk || od_reg.duty == 3'h0) ? ttc_pkg::DUTY_HALF : od_reg.duty;

	// ==========================================================
	// Clock modulation: eight slots, duty slots on
	logic [7:0] slot_cnt_reg;
	logic [2:0] slot_reg;

	always_ff @(posedge clock) begin
		if (!rst_n || !mod_act) begin
			slot_cnt_reg <= 8'h00;
			slot_reg     <= 3'h0;
		end else if (slot_cnt_reg == 8'(ttc_pkg::SLOT_CYC - 1)) begin
			slot_cnt_reg <= 8'h00;
			slot_reg     <= slot_reg + 3'h1;
		end else begin
			slot_cnt_reg <= slot_cnt_reg + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			core_clk_en <= 1'b1;
		end else if (crit_reg || catastrophic_trip_output) begin
			core_clk_en <= 1'b0;
		end else if (mod_act) begin
			core_clk_en <= slot_reg < duty;
		end else begin
			core_clk_en <= 1'b1;
		end
	end

	// ==========================================================
	// Operating point
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			op_point <= ttc_pkg::OP_REQ_RST;
		end else if (auto_op) begin
			op_point <= ttc_pkg::OP_LOW;
		end else begin
			op_point <= op_req_reg;
		end
	end

	// ==========================================================
	// Thermal outputs
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			die_hot_output <= 1'b0;
		end else if (!hot_reg) begin
			die_hot_output <= 1'b0;
		end else if (!low_power_state) begin
			die_hot_output <= 1'b1;
		end
	end

	// Latched until reset; drives no bus activity
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			catastrophic_trip_output <= 1'b0;
		end else if (crit_reg) begin
			catastrophic_trip_output <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			throttle_circuit <= 1'b0;
		end else begin
			throttle_circuit <= mod_act || auto_op;
		end
	end

	// ==========================================================
	// Snoop pass-through, unaffected by throttling
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			snoop_ack <= 1'b0;
		end else begin
			snoop_ack <= snoop_req;
		end
	end

	// ==========================================================
	// Interrupt latching
	logic irq_pend_reg;
	logic irq_pend_next;

	always_comb begin
		irq_pend_next = irq_pend_reg;
		if (irq_service && irq_taken) begin
			irq_pend_next = 1'b0;
		end
		if (irq_req) begin
			irq_pend_next = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_pend_reg <= 1'b0;
			irq_service  <= 1'b0;
		end else begin
			irq_pend_reg <= irq_pend_next;
			irq_service  <= irq_pend_next && core_clk_en;
		end
	end

	// ==========================================================
	// Event status, enable and interrupt output
	logic                      auto_act_d_reg;
	logic                      trip_d_reg;
	logic [ttc_pkg::INT_W-1:0] int_stat_reg;
	logic [ttc_pkg::INT_W-1:0] int_set;
	logic [ttc_pkg::INT_W-1:0] int_clr;

	assign int_set = {catastrophic_trip_output && !trip_d_reg,
		!auto_act && auto_act_d_reg,
		auto_act && !auto_act_d_reg};
	assign int_clr = (bus.wr && bus.addr == ttc_pkg::ADDR_INT_CLR) ?
		bus.wdata[ttc_pkg::INT_W-1:0] : '0;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			auto_act_d_reg <= 1'b0;
			trip_d_reg     <= 1'b0;
			int_stat_reg   <= '0;
		end else begin
			auto_act_d_reg <= auto_act;
			trip_d_reg     <= catastrophic_trip_output;
			int_stat_reg   <= (int_stat_reg & ~int_clr) | int_set;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((int_stat_reg & ~int_clr) | int_set) & int_en_reg);
		end
	end

	// ==========================================================
	// Read port
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata <= 32'h0000_0000;
		end else if (bus.rd) begin
			case (bus.addr)
				ttc_pkg::ADDR_CTRL:     rdata <= {30'h0, ctrl_reg.variant, ctrl_reg.auto_en};
				ttc_pkg::ADDR_ONDEMAND: rdata <= {27'h0, od_reg.en, od_reg.duty, 1'b0};
				ttc_pkg::ADDR_OP_REQ:   rdata <= {24'h0, op_req_reg};
				ttc_pkg::ADDR_STATUS: begin
					rdata <= {16'h0, op_point, irq_pend_reg, core_clk_en, state_reg,
						catastrophic_trip_output, die_hot_output, auto_act, throttle_circuit};
				end
				ttc_pkg::ADDR_INT_STAT: rdata <= {29'h0, int_stat_reg};
				ttc_pkg::ADDR_INT_EN:   rdata <= {29'h0, int_en_reg};
				default:                rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end
endmodule : ttc_top
`default_nettype wire

// [verification/test_thermal_throttle_control.sv]
// Testbench: registers, throttling, interrupts and trip of the throttle control
`timescale 1ns/10ps
`default_nettype none
module test_thermal_throttle_control;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_d = 1'b0;
	logic        over_temp_async = 1'b0;
	logic        crit_temp_async = 1'b0;
	logic        low_power_state = 1'b0;
	logic [31:0] rdata;
	logic [7:0]  op_point;
	logic        snoop_req, snoop_ack, irq_req, irq_taken, irq_service;
	logic        core_clk_en, die_hot_output, catastrophic_trip_output, throttle_circuit, irq;
	logic [31:0] exp_q[$];
	int          failures = 0;
	int          num_checks = 0;
	int          cyc = 0;

	always #20 clock = ~clock;

	ttc_top ttc_top_i (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .over_temp_async, .crit_temp_async,
		.low_power_state, .snoop_req, .snoop_ack, .irq_req, .irq_taken, .irq_service, .core_clk_en,
		.op_point, .die_hot_output, .catastrophic_trip_output, .throttle_circuit, .irq);
	ttc_core_model ttc_core_model_i (.clock, .rst_n, .irq_service, .snoop_req, .irq_req, .irq_taken);

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock);
		wr    <= 1'b0;
		@(posedge clock);
	endtask : wr_reg

	task rd_reg(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd   <= 1'b0;
		@(posedge clock);
	endtask : rd_reg

	// Core clock enable high cycles over one modulation period
	task count_en(input int exp);
		int c;
		c = 0;
		repeat (80) begin
			@(posedge clock);
			c += (core_clk_en === 1'b1);
		end
		chk("clock duty", c, exp);
	endtask : count_en

	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// Read data watcher and hang limit
	always @(posedge clock) begin
		rd_d <= rd;
		if (rd_d === 1'b1)
			chk("rdata", rdata, exp_q.pop_front());
		cyc++;
		if (cyc == 20000) begin
			failures++;
			report_and_stop;
		end
	end

	initial begin
		logic [7:0] v;
		void'($urandom(23));
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		chk("op reset", op_point, {24'h0, ttc_pkg::OP_REQ_RST});
		chk("clk reset", core_clk_en, 1'b1);
		rd_reg(ttc_pkg::ADDR_OP_REQ, {24'h0, ttc_pkg::OP_REQ_RST});
		rd_reg(ttc_pkg::ADDR_INT_EN, {29'h0, ttc_pkg::INT_EN_RST});
		rd_reg(ttc_pkg::ADDR_INT_CLR, 32'h0);
		rd_reg(8'h20, 32'h0);
		$display("test 1 done");
		v = 8'($urandom_range(254, 1));
		wr_reg(ttc_pkg::ADDR_OP_REQ, {24'h0, v});
		rd_reg(ttc_pkg::ADDR_OP_REQ, {24'h0, v});
		wr_reg(ttc_pkg::ADDR_INT_EN, 32'h7);
		wr_reg(ttc_pkg::ADDR_CTRL, 32'h3);
		over_temp_async <= 1'b1;
		repeat (40) if (throttle_circuit !== 1'b1) @(posedge clock);
		chk("throttle", throttle_circuit, 1'b1);
		repeat (2) @(posedge clock);
		chk("op low", op_point, {24'h0, ttc_pkg::OP_LOW});
		chk("clk run", core_clk_en, 1'b1);
		chk("hot", die_hot_output, 1'b1);
		chk("irq", irq, 1'b1);
		rd_reg(ttc_pkg::ADDR_INT_STAT, 32'h1);
		over_temp_async <= 1'b0;
		repeat (10) @(posedge clock);
		chk("hysteresis", throttle_circuit, 1'b1);
		repeat (60) if (throttle_circuit !== 1'b0) @(posedge clock);
		repeat (2) @(posedge clock);
		chk("op back", op_point, {24'h0, v});
		rd_reg(ttc_pkg::ADDR_INT_STAT, 32'h3);
		wr_reg(ttc_pkg::ADDR_INT_CLR, 32'h7);
		rd_reg(ttc_pkg::ADDR_INT_STAT, 32'h0);
		chk("irq clear", irq, 1'b0);
		$display("test 2 done");
		wr_reg(ttc_pkg::ADDR_CTRL, 32'h1);
		wr_reg(ttc_pkg::ADDR_ONDEMAND, 32'h12);
		rd_reg(ttc_pkg::ADDR_ONDEMAND, 32'h12);
		rd_reg(ttc_pkg::ADDR_CTRL, 32'h1);
		repeat (80) @(posedge clock);
		count_en(10);
		over_temp_async <= 1'b1;
		repeat (100) @(posedge clock);
		count_en(40);
		over_temp_async <= 1'b0;
		repeat (120) @(posedge clock);
		count_en(10);
		$display("test 3 done");
		wr_reg(ttc_pkg::ADDR_CTRL, 32'h0);
		for (int d = 0; d < 8; d++) begin
			wr_reg(ttc_pkg::ADDR_ONDEMAND, 32'h10 | 32'(d << 1));
			repeat (80) @(posedge clock);
			count_en(d == 0 ? 40 : d * 10);
		end
		wr_reg(ttc_pkg::ADDR_ONDEMAND, 32'h0);
		$display("test 4 done");
		repeat (100) if (throttle_circuit !== 1'b0) @(posedge clock);
		low_power_state <= 1'b1;
		over_temp_async <= 1'b1;
		repeat (10) @(posedge clock);
		chk("auto off", throttle_circuit, 1'b0);
		chk("hot in sleep", die_hot_output, 1'b0);
		low_power_state <= 1'b0;
		repeat (3) @(posedge clock);
		chk("hot", die_hot_output, 1'b1);
		low_power_state <= 1'b1;
		repeat (3) @(posedge clock);
		chk("hot kept", die_hot_output, 1'b1);
		over_temp_async <= 1'b0;
		low_power_state <= 1'b0;
		$display("test 5 done");
		wr_reg(ttc_pkg::ADDR_INT_CLR, 32'h7);
		wr_reg(ttc_pkg::ADDR_INT_EN, 32'h3);
		crit_temp_async <= 1'b1;
		repeat (20) if (catastrophic_trip_output !== 1'b1) @(posedge clock);
		repeat (2) @(posedge clock);
		chk("trip", catastrophic_trip_output, 1'b1);
		chk("trip clk", core_clk_en, 1'b0);
		chk("irq masked", irq, 1'b0);
		rd_reg(ttc_pkg::ADDR_INT_STAT, 32'h4);
		wr_reg(ttc_pkg::ADDR_INT_EN, 32'h7);
		crit_temp_async <= 1'b0;
		repeat (10) @(posedge clock);
		chk("irq trip", irq, 1'b1);
		chk("trip held", catastrophic_trip_output, 1'b1);
		$display("test 6 done");
		report_and_stop;
	end
endmodule : test_thermal_throttle_control
`default_nettype wire

// [verification/ttc_chk.sv]
// Checker: port-level timing relations of the thermal throttle control
`timescale 1ns/10ps
`default_nettype none
module ttc_chk (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// Inputs seen
	input wire logic        rd,
	input wire logic        over_temp_async,
	input wire logic        crit_temp_async,
	input wire logic        low_power_state,
	input wire logic        snoop_req,
	// Outputs seen
	input wire logic [31:0] rdata,
	input wire logic        snoop_ack,
	input wire logic        irq_service,
	input wire logic        core_clk_en,
	input wire logic        die_hot_output,
	input wire logic        catastrophic_trip_output,
	input wire logic        throttle_circuit
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_snoop_echo: assert property ($past(rst_n) |-> snoop_ack == $past(snoop_req))
		else $error("snoop ack is not a copy of the request");
	a_service_run: assert property (irq_service |-> $past(core_clk_en))
		else $error("interrupt serviced while clocks stopped");
	a_gate_throttle: assert property (!core_clk_en && !catastrophic_trip_output
		|-> throttle_circuit || $past(throttle_circuit))
		else $error("clocks stopped without throttling");
	a_hot_no_new: assert property ($rose(die_hot_output) |-> !$past(low_power_state))
		else $error("hot output newly set in low power state");
	a_hot_synced: assert property ($rose(die_hot_output) |-> $past(over_temp_async, 4))
		else $error("hot output ahead of its synchroniser");
	a_trip_cause: assert property ($rose(catastrophic_trip_output) |-> $past(crit_temp_async, 4))
		else $error("trip output without critical input");
	a_trip_sticky: assert property (catastrophic_trip_output |=> catastrophic_trip_output)
		else $error("trip output released before reset");
	a_trip_stop: assert property (catastrophic_trip_output |=> !core_clk_en)
		else $error("clocks run after trip");
	a_rdata_idle: assert property ($past(rst_n) && !$past(rd) |-> rdata == 32'h0)
		else $error("read data outside its cycle");
endmodule : ttc_chk

bind ttc_top ttc_chk ttc_chk_i (.clock, .rst_n, .rd, .over_temp_async, .crit_temp_async, .low_power_state,
	.snoop_req, .rdata, .snoop_ack, .irq_service, .core_clk_en, .die_hot_output, .catastrophic_trip_output,
	.throttle_circuit);
`default_nettype wire

// [verification/ttc_core_model.sv]
// Partner model: core side snoop and interrupt traffic
`timescale 1ns/10ps
`default_nettype none
module ttc_core_model (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Core handshake
	input  wire logic irq_service,
	output logic      snoop_req,
	output logic      irq_req,
	output logic      irq_taken
);
	// Held low by rst_n from the first edge on
	always @(posedge clock) begin
		snoop_req <= rst_n && ($urandom % 4 == 0);
		irq_req   <= rst_n && ($urandom % 16 == 0);
	end
	// Accept a presented interrupt once, only when shown
	always @(posedge clock) begin
		irq_taken <= rst_n && irq_service && !irq_taken;
	end
endmodule : ttc_core_model
`default_nettype wire
